// [rtl/bolc_pkg.sv]
package bolc_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_THR = 8'h08;
	localparam logic [7:0] OFS_RHR = 8'h0c;
	localparam logic [7:0] OFS_CAUSE = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] FLAG_CHAR = 8'h7e;
	localparam logic [7:0] ABORT_CHAR = 8'hff;
	localparam logic [7:0] IDLE_CHAR = 8'hff;
	localparam logic [7:0] GLOBAL_ADDR = 8'hff;
	localparam logic [7:0] CAUSE_LATE_MASK = 8'hf8;
	localparam logic [7:0] CAUSE_IRQ_MASK = 8'hf9;
	localparam logic [2:0] STAT_LATE_MASK = 3'h7;
	localparam int CB_CMD = 0;
	localparam int CB_MODEM = 3;
	localparam int CB_UNDER = 4;
	localparam int CB_TXDONE = 5;
	localparam int CB_REOM_ERR = 6;
	localparam int CB_REOM_OK = 7;
	localparam int SB_OVR = 1;
	localparam int SB_ABT = 2;
	localparam logic [2:0] RESET_EDGES = 3'h5;
	localparam logic [2:0] STUFF_ONES = 3'h5;
	localparam logic [2:0] RUN_ONES = 3'h7;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [5:0] FLAG_TAIL = 6'h07;
	localparam logic [5:0] GA_CNT = 6'h06;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam logic [1:0] B2B_LOCK = 2'h2;
	localparam logic [3:0] FULL_CHAR = 4'h8;
	localparam logic [2:0] HDR_BASE = 3'h2;
	localparam int MIN_W = 6;
	localparam logic [23:0] MIN_CFG0 = {6'h13, 6'h15, 6'h17, 6'h19};
	localparam logic [23:0] MIN_CFG1 = {6'h16, 6'h17, 6'h18, 6'h19};
	localparam logic [5:0] MIN_CFG2 = 6'h19;

	typedef enum logic [1:0] {
		CMD_DATA = 2'b00,
		CMD_ABORT = 2'b01,
		CMD_FLAG = 2'b10,
		CMD_FCS = 2'b11
	} bolc_cmd_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_FLAG = 2'b01,
		TX_DATA = 2'b10,
		TX_ABORT = 2'b11
	} bolc_txst_e;

	typedef struct packed {
		logic hdlc;
		logic loop;
		logic auto_flag;
		logic addr_cmp;
		logic [1:0] frame_cfg;
		logic [1:0] char_len;
		bolc_cmd_e cmd;
		logic act_rec;
		logic transmit_activate_control;
	} bolc_ctrl_s;

	function automatic logic [5:0] min_frame_bits(input logic [1:0] cfg, input logic [1:0] len);
		logic [5:0] m;
		m = MIN_CFG2;
		if (cfg == 2'h0) begin
			m = MIN_CFG0[MIN_W*len +: MIN_W];
		end else if (cfg == 2'h1) begin
			m = MIN_CFG1[MIN_W*len +: MIN_W];
		end
		return m;
	endfunction : min_frame_bits

	function automatic logic [3:0] char_width(input logic [1:0] cfg, input logic [1:0] len,
		input logic [2:0] idx);
		return (idx < HDR_BASE + {1'b0, cfg}) ? FULL_CHAR : FULL_CHAR - {2'h0, len};
	endfunction : char_width
endpackage : bolc_pkg

// [rtl/bolc_sync.sv]
`timescale 1ns/100ps
module bolc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1, s2, s3;

	// First stage feeds only the second, so it may settle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign q = s2;
	assign rise = s2 & ~s3;
	assign fall = ~s2 & s3;
endmodule : bolc_sync

// [rtl/bolc_clr_delay.sv]
`timescale 1ns/100ps
module bolc_clr_delay (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic tick,
	output logic fire
);
	logic pend, next_pend, next_fire;

	// A read arms it; the next bit clock rising edge fires the clear
	always_comb begin
		next_pend = arm | (pend & ~tick);
		next_fire = pend & tick;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			fire <= 1'b0;
		end else begin
			pend <= next_pend;
			fire <= next_fire;
		end
	end
endmodule : bolc_clr_delay

// [rtl/bolc_top.sv]
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Abort or too short frame sets the abort-or-invalid flag
// - Minimum frame bits depend on char length and header layout
// - Master clear needs no clock; core waits 2.5 transmit clocks after release
// - Cause read clears bit 0 at once, bits 3-7 one bit time later
// - Line status read clears bits 0-2 one bit time later
// - Loop go-ahead is sent as idle or abort right after a flag
// - Transmit and receive bit clocks are handled independently
// - Transmitter and receiver enable separately: simplex, half or full duplex
// - Interrupts for command, modem change, underrun, tx complete, end of message; holding registers only drive drq_in/drq_out
// - Loop mode works only with the SDLC protocol selected
// - In loop mode a frame matching our address is captured
// - In loop mode received frames are repeated downstream except while we hold the line after a go-ahead
// - Own transmission in loop starts only after a go-ahead
module bolc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic master_clear_input_n,
	input wire logic transmit_bit_clock,
	input wire logic receive_bit_clock,
	input wire logic rxd,
	input wire logic end_of_block_input_n,
	input wire logic dsr_n,
	output logic txd,
	output logic interrupt_request_output,
	output logic drq_out,
	output logic drq_in
);
	logic rst_n, core_rdy, tc_rise, tc_edge, rc_rise, rxd_s, eob_act, dsr_chg;
	logic [4:0] pin_q, pin_rise, pin_fall;
	logic [2:0] reset_cnt, next_reset_cnt;
	bolc_pkg::bolc_ctrl_s ctrl, next_ctrl;
	logic [7:0] addr_reg, next_addr_reg, thr, next_thr, rhr, next_rhr;
	logic [31:0] next_prdata, rdval;
	logic next_pready, next_pslverr, access, done, hit;
	logic wr_ctrl, wr_addr, wr_thr, rd_rhr, rd_cause, rd_stat;
	bolc_pkg::bolc_txst_e tx_st, next_tx_st;
	logic [7:0] tx_sh, next_tx_sh, tx_set, rx_set, cause, next_cause, cause_clr;
	logic [2:0] tx_bit, next_tx_bit, tx_ones, next_tx_ones;
	logic [1:0] b2b, next_b2b;
	logic thr_full, next_thr_full, next_txd, next_drq_out, tx_load;
	logic loop_on, tx_own, loop_rep;
	logic [7:0] rx_raw, next_rx_raw, rx_char, next_rx_char, raw_n, char_n, aligned;
	logic [2:0] rx_ones, next_rx_ones, ones_n, rx_cidx, next_rx_cidx;
	logic [5:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_cbit, next_rx_cbit, width;
	logic rx_in, next_rx_in, rx_cap, next_rx_cap, go_ahead, next_go_ahead, next_drq_in;
	logic frame_close, frame_short, abort_det;
	logic [2:0] stat, next_stat, stat_set;
	logic next_interrupt_request_output, ir_fire, sr_fire;
	logic [4:0] cause_hi;
	logic [7:0] cause_irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!rst_n);

	// Master clear acts as an asynchronous reset, no clock needed
	assign rst_n = presetn & master_clear_input_n;

	bolc_sync #(.W(5), .INIT(5'h1c)) u_sync (
		.clk(pclk),
		.rst_n(rst_n),
		.d({dsr_n, end_of_block_input_n, rxd, receive_bit_clock, transmit_bit_clock}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// Each bit clock has its own edge detector; no ratio between them assumed
	assign tc_rise = pin_rise[0];
	assign rc_rise = pin_rise[1];
	assign tc_edge = pin_rise[0] | pin_fall[0];
	assign rxd_s = pin_q[2];
	assign eob_act = ~pin_q[3];
	assign dsr_chg = pin_rise[4] | pin_fall[4];

	// Five transmit clock edges make the 2.5 cycles of internal reset
	always_comb begin
		next_reset_cnt = reset_cnt;
		if (!core_rdy && tc_edge) begin
			next_reset_cnt = reset_cnt + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_cnt <= 3'h0;
		end else begin
			reset_cnt <= next_reset_cnt;
		end
	end

	assign core_rdy = (reset_cnt == bolc_pkg::RESET_EDGES);

	a_reset_txd_idle: assert property (!core_rdy |=> txd)
		else $error("txd not idle during internal reset");
	a_reset_ready_edge: assert property ($rose(core_rdy) |-> $past(tc_edge))
		else $error("core ready without a transmit clock edge");

	// APB slave, one wait state so read data comes from a register
	assign access = psel & penable;
	assign done = access & pready;
	assign wr_ctrl = done & pwrite & (paddr == bolc_pkg::OFS_CTRL);
	assign wr_addr = done & pwrite & (paddr == bolc_pkg::OFS_ADDR);
	assign wr_thr = done & pwrite & (paddr == bolc_pkg::OFS_THR);
	assign rd_rhr = done & ~pwrite & (paddr == bolc_pkg::OFS_RHR);
	assign rd_cause = done & ~pwrite & (paddr == bolc_pkg::OFS_CAUSE);
	assign rd_stat = done & ~pwrite & (paddr == bolc_pkg::OFS_STAT);

	always_comb begin
		hit = 1'b1;
		rdval = 32'h0;
		case (paddr)
			bolc_pkg::OFS_CTRL: rdval = 32'(ctrl);
			bolc_pkg::OFS_ADDR: rdval = {24'h0, addr_reg};
			bolc_pkg::OFS_THR: rdval = 32'h0;
			bolc_pkg::OFS_RHR: rdval = {24'h0, rhr};
			bolc_pkg::OFS_CAUSE: rdval = {24'h0, cause[7:3], drq_in, drq_out, cause[0]};
			bolc_pkg::OFS_STAT: rdval = {28'h0, ~pin_q[4], stat};
			default: hit = 1'b0;
		endcase
		next_pready = access & ~pready;
		next_pslverr = access & ~pready & ~hit;
		next_prdata = (access & ~pready) ? rdval : prdata;
		next_ctrl = wr_ctrl ? bolc_pkg::bolc_ctrl_s'(pwdata[$bits(bolc_pkg::bolc_ctrl_s)-1:0]) : ctrl;
		next_addr_reg = wr_addr ? pwdata[7:0] : addr_reg;
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			ctrl <= '0;
			addr_reg <= 8'h00;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			ctrl <= next_ctrl;
			addr_reg <= next_addr_reg;
		end
	end

	// Loop: repeat line until a go-ahead hands us the line
	assign loop_on = ctrl.loop & ~ctrl.hdlc;
	assign tx_own = go_ahead & (ctrl.transmit_activate_control | (tx_st != bolc_pkg::TX_IDLE));
	assign loop_rep = loop_on & ~tx_own;

	a_hdlc_no_loop: assert property (ctrl.hdlc |-> !loop_rep)
		else $error("loop repeating with HDLC selected");

	// Transmitter; bit time is the transmit clock rising edge
	always_comb begin
		next_tx_st = tx_st;
		next_tx_sh = tx_sh;
		next_tx_bit = tx_bit;
		next_tx_ones = tx_ones;
		next_b2b = b2b;
		next_thr = thr;
		next_thr_full = thr_full;
		next_txd = txd;
		tx_set = 8'h00;
		tx_load = 1'b0;
		if (!ctrl.transmit_activate_control) begin
			next_b2b = 2'h0;
		end
		if (!core_rdy) begin
			next_tx_st = bolc_pkg::TX_IDLE;
			next_tx_sh = bolc_pkg::IDLE_CHAR;
			next_tx_bit = 3'h0;
			next_tx_ones = 3'h0;
			next_txd = 1'b1;
		end else if (loop_rep) begin
			next_txd = rxd_s;
		end else if (tc_rise) begin
			if (tx_st == bolc_pkg::TX_DATA && tx_ones == bolc_pkg::STUFF_ONES) begin
				next_txd = 1'b0;
				next_tx_ones = 3'h0;
			end else begin
				next_txd = tx_sh[0];
				next_tx_ones = (tx_st == bolc_pkg::TX_DATA && tx_sh[0]) ? tx_ones + 3'h1 : 3'h0;
				next_tx_sh = {1'b1, tx_sh[7:1]};
				next_tx_bit = tx_bit + 3'h1;
				tx_load = (tx_bit == bolc_pkg::LAST_BIT);
			end
		end
		if (tx_load) begin
			next_tx_bit = 3'h0;
			next_tx_st = bolc_pkg::TX_FLAG;
			next_tx_sh = bolc_pkg::FLAG_CHAR;
			if (!ctrl.transmit_activate_control) begin
				// Closing flag then idle ones: the go-ahead in loop mode
				if (tx_st != bolc_pkg::TX_DATA) begin
					next_tx_st = bolc_pkg::TX_IDLE;
					next_tx_sh = bolc_pkg::IDLE_CHAR;
				end
			end else if (ctrl.cmd == bolc_pkg::CMD_ABORT || ctrl.cmd == bolc_pkg::CMD_FLAG) begin
				if (ctrl.cmd == bolc_pkg::CMD_ABORT) begin
					next_tx_st = bolc_pkg::TX_ABORT;
					next_tx_sh = bolc_pkg::ABORT_CHAR;
				end
				next_b2b = (b2b == 2'h3) ? b2b : b2b + 2'h1;
				tx_set[bolc_pkg::CB_CMD] = 1'b1;
			end else if (ctrl.cmd == bolc_pkg::CMD_FCS || eob_act) begin
				tx_set[bolc_pkg::CB_TXDONE] = (tx_st == bolc_pkg::TX_DATA);
			end else if (thr_full && b2b < bolc_pkg::B2B_LOCK) begin
				next_tx_st = bolc_pkg::TX_DATA;
				next_tx_sh = thr;
				next_thr_full = 1'b0;
				next_b2b = 2'h0;
			end else if (tx_st == bolc_pkg::TX_DATA) begin
				// Underrun: one abort, or straight to flag fill with auto flag
				tx_set[bolc_pkg::CB_UNDER] = 1'b1;
				if (!ctrl.auto_flag) begin
					next_tx_st = bolc_pkg::TX_ABORT;
					next_tx_sh = bolc_pkg::ABORT_CHAR;
				end
			end
		end
		if (wr_thr) begin
			next_thr = pwdata[7:0];
			next_thr_full = 1'b1;
		end
		next_drq_out = core_rdy & ctrl.transmit_activate_control & ~next_thr_full;
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st <= bolc_pkg::TX_IDLE;
			tx_sh <= bolc_pkg::IDLE_CHAR;
			tx_bit <= 3'h0;
			tx_ones <= 3'h0;
			b2b <= 2'h0;
			thr <= 8'h00;
			thr_full <= 1'b0;
			txd <= 1'b1;
			drq_out <= 1'b0;
		end else begin
			tx_st <= next_tx_st;
			tx_sh <= next_tx_sh;
			tx_bit <= next_tx_bit;
			tx_ones <= next_tx_ones;
			b2b <= next_b2b;
			thr <= next_thr;
			thr_full <= next_thr_full;
			txd <= next_txd;
			drq_out <= next_drq_out;
		end
	end

	a_data_refused: assert property (tx_load && b2b >= bolc_pkg::B2B_LOCK |=>
		tx_st != bolc_pkg::TX_DATA) else $error("data sent while command lock held");
	a_loop_repeat: assert property (loop_rep && core_rdy |=> txd == $past(rxd_s))
		else $error("loop mode did not repeat the line");

	// Receiver; bit time is the receive clock rising edge
	always_comb begin
		next_rx_raw = rx_raw;
		next_rx_ones = rx_ones;
		next_rx_cnt = rx_cnt;
		next_rx_char = rx_char;
		next_rx_cbit = rx_cbit;
		next_rx_cidx = rx_cidx;
		next_rx_in = rx_in;
		next_rx_cap = rx_cap;
		next_rhr = rhr;
		next_drq_in = drq_in & ~rd_rhr;
		next_go_ahead = go_ahead;
		raw_n = {rxd_s, rx_raw[7:1]};
		char_n = {rxd_s, rx_char[7:1]};
		ones_n = !rxd_s ? 3'h0 : (rx_ones == bolc_pkg::RUN_ONES) ? rx_ones : rx_ones + 3'h1;
		width = bolc_pkg::char_width(ctrl.frame_cfg, ctrl.char_len, rx_cidx);
		aligned = char_n >> (bolc_pkg::FULL_CHAR - width);
		rx_set = 8'h00;
		stat_set = 3'h0;
		frame_close = 1'b0;
		frame_short = 1'b0;
		abort_det = 1'b0;
		if (!loop_on || (!ctrl.transmit_activate_control && tx_st == bolc_pkg::TX_IDLE)) begin
			next_go_ahead = 1'b0;
		end
		if (!core_rdy || !ctrl.act_rec) begin
			next_rx_in = 1'b0;
			next_rx_ones = 3'h0;
		end else if (rc_rise) begin
			next_rx_raw = raw_n;
			next_rx_ones = ones_n;
			if (raw_n == bolc_pkg::FLAG_CHAR) begin
				if (rx_in && rx_cnt > bolc_pkg::FLAG_TAIL) begin
					frame_close = 1'b1;
					frame_short = (rx_cnt - bolc_pkg::FLAG_TAIL) <
						bolc_pkg::min_frame_bits(ctrl.frame_cfg, ctrl.char_len);
					stat_set[bolc_pkg::SB_ABT] = frame_short;
					rx_set[bolc_pkg::CB_REOM_ERR] = rx_cap & frame_short;
					rx_set[bolc_pkg::CB_REOM_OK] = rx_cap & ~frame_short;
				end
				next_rx_in = 1'b1;
				next_rx_cnt = 6'h00;
				next_rx_cbit = 4'h0;
				next_rx_cidx = 3'h0;
				next_rx_cap = 1'b0;
			end else if (ones_n == bolc_pkg::RUN_ONES && rx_ones != bolc_pkg::RUN_ONES) begin
				// Seven ones right after a flag is a go-ahead, later an abort
				if (rx_in && rx_cnt == bolc_pkg::GA_CNT) begin
					next_go_ahead = loop_on & ctrl.transmit_activate_control;
				end else if (rx_in) begin
					abort_det = 1'b1;
					stat_set[bolc_pkg::SB_ABT] = 1'b1;
					rx_set[bolc_pkg::CB_REOM_ERR] = rx_cap;
				end
				next_rx_in = 1'b0;
			end else if (rx_in && !(rx_ones == bolc_pkg::STUFF_ONES && !rxd_s)) begin
				next_rx_cnt = (rx_cnt == bolc_pkg::CNT_MAX) ? rx_cnt : rx_cnt + 6'h01;
				next_rx_char = char_n;
				next_rx_cbit = rx_cbit + 4'h1;
				if (rx_cbit + 4'h1 == width) begin
					next_rx_cbit = 4'h0;
					next_rx_cidx = (rx_cidx == 3'h7) ? rx_cidx : rx_cidx + 3'h1;
					if (rx_cidx == 3'h0) begin
						next_rx_cap = !ctrl.addr_cmp || aligned == addr_reg ||
							aligned == bolc_pkg::GLOBAL_ADDR;
					end
					if (next_rx_cap) begin
						next_rhr = aligned;
						stat_set[bolc_pkg::SB_OVR] = drq_in & ~rd_rhr;
						next_drq_in = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_raw <= 8'h00;
			rx_ones <= 3'h0;
			rx_cnt <= 6'h00;
			rx_char <= 8'h00;
			rx_cbit <= 4'h0;
			rx_cidx <= 3'h0;
			rx_in <= 1'b0;
			rx_cap <= 1'b0;
			rhr <= 8'h00;
			drq_in <= 1'b0;
			go_ahead <= 1'b0;
		end else begin
			rx_raw <= next_rx_raw;
			rx_ones <= next_rx_ones;
			rx_cnt <= next_rx_cnt;
			rx_char <= next_rx_char;
			rx_cbit <= next_rx_cbit;
			rx_cidx <= next_rx_cidx;
			rx_in <= next_rx_in;
			rx_cap <= next_rx_cap;
			rhr <= next_rhr;
			drq_in <= next_drq_in;
			go_ahead <= next_go_ahead;
		end
	end

	a_short_sets_abt: assert property (frame_close && frame_short |=> stat[bolc_pkg::SB_ABT])
		else $error("short frame left abort flag clear");
	a_abort_sets_abt: assert property (abort_det |=> stat[bolc_pkg::SB_ABT])
		else $error("abort left abort flag clear");

	// Late clears: cause bits run off the transmit clock, line status off the receive clock
	bolc_clr_delay u_ir_clr (
		.clk(pclk),
		.rst_n(rst_n),
		.arm(rd_cause),
		.tick(tc_rise),
		.fire(ir_fire)
	);

	bolc_clr_delay u_sr_clr (
		.clk(pclk),
		.rst_n(rst_n),
		.arm(rd_stat),
		.tick(rc_rise),
		.fire(sr_fire)
	);

	// New events win over a clear in the same cycle
	always_comb begin
		cause_clr = 8'h00;
		cause_clr[bolc_pkg::CB_CMD] = rd_cause;
		if (ir_fire) begin
			cause_clr = cause_clr | bolc_pkg::CAUSE_LATE_MASK;
		end
		next_cause = (cause & ~cause_clr) | tx_set | rx_set;
		next_cause[bolc_pkg::CB_MODEM] = next_cause[bolc_pkg::CB_MODEM] | dsr_chg;
		next_stat = (stat & ~(sr_fire ? bolc_pkg::STAT_LATE_MASK : 3'h0)) | stat_set;
		next_interrupt_request_output = |(cause & bolc_pkg::CAUSE_IRQ_MASK);
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			cause <= 8'h00;
			stat <= 3'h0;
			interrupt_request_output <= 1'b0;
		end else begin
			cause <= next_cause;
			stat <= next_stat;
			interrupt_request_output <= next_interrupt_request_output;
		end
	end

	assign cause_hi = cause[7:3];
	assign cause_irq = cause & bolc_pkg::CAUSE_IRQ_MASK;

	sequence s_cause_read;
		rd_cause && !tx_set[bolc_pkg::CB_CMD];
	endsequence

	a_cause_bit0_now: assert property (s_cause_read |=> !cause[bolc_pkg::CB_CMD])
		else $error("cause bit 0 not cleared by read");
	a_cause_hi_late: assert property (rd_cause && !ir_fire |=>
		(cause_hi & $past(cause_hi)) == $past(cause_hi))
		else $error("cause high bits cleared too early");
	a_stat_late: assert property (rd_stat && !sr_fire |=>
		(stat & $past(stat)) == $past(stat))
		else $error("line status cleared too early");
	a_interrupt_request_output_cause: assert property ((|cause_irq) |=> interrupt_request_output)
		else $error("interrupt request missing with cause pending");
endmodule : bolc_top

// [tb/bolc_line_model.sv]
`timescale 1ns/100ps
module bolc_line_model #(
	parameter int HALF_TX = 100,
	parameter int HALF_RX = 100,
	parameter int RX_SKEW = 37
) (
	output logic transmit_bit_clock,
	output logic receive_bit_clock,
	output logic rxd,
	output logic dsr_n,
	input wire logic txd
);
	int flags_seen = 0;
	logic [7:0] tx_window = 8'hff;

	initial begin
		transmit_bit_clock = 1'b0;
		forever #HALF_TX transmit_bit_clock = ~transmit_bit_clock;
	end
	// Skewed start so the two equal-rate bit clocks keep a fixed 37 ns offset
	initial begin
		receive_bit_clock = 1'b0;
		#RX_SKEW;
		forever #HALF_RX receive_bit_clock = ~receive_bit_clock;
	end
	initial begin
		rxd = 1'b1;
		dsr_n = 1'b1;
	end
	// Bits leave on the rising edge, so the far end samples on the falling one
	always @(negedge transmit_bit_clock) begin
		tx_window = {txd, tx_window[7:1]};
		if (tx_window == bolc_pkg::FLAG_CHAR) begin
			flags_seen++;
		end
	end

	task automatic set_dsr(input logic v);
		@(negedge receive_bit_clock);
		dsr_n = v;
	endtask : set_dsr

	task automatic put_bit(input logic b);
		@(negedge receive_bit_clock);
		rxd = b;
	endtask : put_bit

	// Opening flag, payload with zero insertion, raw closer, then marking idle
	task automatic send_frame(input logic [31:0] data, input int nbits, input logic [7:0] closer);
		int ones;
		ones = 0;
		for (int i = 0; i < 8; i++) begin
			put_bit(bolc_pkg::FLAG_CHAR[i]);
		end
		for (int i = 0; i < nbits; i++) begin
			put_bit(data[i]);
			ones = data[i] ? ones + 1 : 0;
			if (ones == 5) begin
				put_bit(1'b0);
				ones = 0;
			end
		end
		for (int i = 0; i < 8; i++) begin
			put_bit(closer[i]);
		end
		put_bit(1'b1);
	endtask : send_frame
endmodule : bolc_line_model

// [tb/testbench.sv]
`timescale 1ns/100ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin mismatches++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); end end
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic master_clear_input_n, end_of_block_input_n, txd;
	logic interrupt_request_output, drq_out, drq_in;
	logic transmit_bit_clock, receive_bit_clock, rxd, dsr_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int mismatches = 0;
	int samples_checked = 0;
	int fs;
	logic [7:0] got[$];
	// Frame table: control, bit count, payload, closer, expected cause bits 7:6
	logic [7:0] f_ctrl [7] = '{8'h02, 8'h02, 8'h02, 8'h32, 8'h32, 8'h72, 8'h72};
	int f_bits [7] = '{24, 25, 16, 18, 19, 21, 22};
	logic [31:0] f_data [7] = '{32'h003c5aa5, 32'h013c5aa5, 32'h00005aa5, 32'h00015aa5,
		32'h00055aa5, 32'h001c5aa5, 32'h003c5aa5};
	logic [7:0] f_close [7] = '{8'h7e, 8'h7e, 8'hff, 8'h7e, 8'h7e, 8'h7e, 8'h7e};
	logic [1:0] f_cause [7] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2};

	bolc_top i_bolc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_clear_input_n(master_clear_input_n),
		.transmit_bit_clock(transmit_bit_clock), .receive_bit_clock(receive_bit_clock),
		.rxd(rxd), .end_of_block_input_n(end_of_block_input_n), .dsr_n(dsr_n), .txd(txd),
		.interrupt_request_output(interrupt_request_output), .drq_out(drq_out),
		.drq_in(drq_in));
	bolc_line_model i_bolc_line_model (.transmit_bit_clock(transmit_bit_clock),
		.receive_bit_clock(receive_bit_clock), .rxd(rxd), .dsr_n(dsr_n), .txd(txd));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#400000;
		mismatches++;
		stop_test();
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			mismatches++;
			stop_test();
		end
	endtask : apb

	task automatic wait_irq();
		int n;
		for (n = 0; n < 800 && interrupt_request_output !== 1'b1; n++) begin
			@(posedge pclk);
		end
		if (n >= 800) begin
			mismatches++;
			stop_test();
		end
	endtask : wait_irq

	// Reads every character as it lands so no overrun muddies the frame verdict
	task automatic drain();
		for (int n = 0; n < 420; n++) begin
			@(posedge pclk);
			if (drq_in === 1'b1) begin
				apb(1'b0, bolc_pkg::OFS_RHR, 32'h0);
				got.push_back(r[7:0]);
			end
		end
	endtask : drain

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		master_clear_input_n = 1'b1;
		end_of_block_input_n = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, bolc_pkg::OFS_CTRL, 32'h0);
		`CHK(r, 32'h0)
		apb(1'b0, 8'h18, 32'h0);
		`CHK({e, r}, 33'h100000000)
		apb(1'b1, bolc_pkg::OFS_ADDR, 32'h5a);
		apb(1'b0, bolc_pkg::OFS_ADDR, 32'h0);
		`CHK(r[7:0], 8'h5a)
		master_clear_input_n <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(txd, 1'b1)
		master_clear_input_n <= 1'b1;
		apb(1'b0, bolc_pkg::OFS_ADDR, 32'h0);
		`CHK(r[7:0], 8'h00)
		repeat (40) @(posedge pclk);
		i_bolc_line_model.set_dsr(1'b0);
		wait_irq();
		apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
		`CHK(r[3], 1'b1)
		repeat (40) @(posedge pclk);
		apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
		`CHK(r[7:3], 5'h00)
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'h9);
		wait_irq();
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'h0);
		repeat (100) @(posedge pclk);
		`CHK(i_bolc_line_model.flags_seen > 0, 1'b1)
		`CHK(txd, 1'b1)
		apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
		`CHK(r[0], 1'b1)
		apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
		`CHK(r[0], 1'b0)
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, bolc_pkg::OFS_CTRL, {24'h0, f_ctrl[i]});
			got.delete();
			fork
				i_bolc_line_model.send_frame(f_data[i], f_bits[i], f_close[i]);
				drain();
			join
			wait_irq();
			apb(1'b0, bolc_pkg::OFS_STAT, 32'h0);
			`CHK(r[2], f_cause[i][0])
			apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
			`CHK(r[7:6], f_cause[i])
			`CHK(got[0], 8'ha5)
			repeat (40) @(posedge pclk);
			apb(1'b0, bolc_pkg::OFS_STAT, 32'h0);
			`CHK(r[2:0], 3'h0)
			apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
			`CHK(r[7:3], 5'h00)
		end
		// End of block closes a data frame; held well past one character
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, bolc_pkg::OFS_THR, 32'h55);
		@(posedge pclk);
		for (int n = 0; n < 200 && drq_out !== 1'b1; n++) begin
			@(posedge pclk);
		end
		`CHK(drq_out, 1'b1)
		end_of_block_input_n <= 1'b0;
		wait_irq();
		repeat (70) @(posedge pclk);
		apb(1'b0, bolc_pkg::OFS_CAUSE, 32'h0);
		`CHK(r[5:4], 2'h2)
		end_of_block_input_n <= 1'b1;
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'h0);
		// Loop mode repeats the line; HDLC selection turns it off
		fs = i_bolc_line_model.flags_seen;
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'h402);
		i_bolc_line_model.send_frame(f_data[1], f_bits[1], f_close[1]);
		repeat (20) @(posedge pclk);
		`CHK(i_bolc_line_model.flags_seen >= fs + 2, 1'b1)
		`CHK(drq_in, 1'b1)
		fs = i_bolc_line_model.flags_seen;
		apb(1'b1, bolc_pkg::OFS_CTRL, 32'hc02);
		i_bolc_line_model.send_frame(f_data[1], f_bits[1], f_close[1]);
		repeat (20) @(posedge pclk);
		`CHK(i_bolc_line_model.flags_seen == fs, 1'b1)
		stop_test();
	end
endmodule : testbench
